// ### bench/scs_meas_model.sv
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_meas_model (
	input  wire        clk,           // System clock.
	input  wire        rst,           // Reset, active high.
	input  wire        meas_req,      // Reading request.
	input  wire [2:0]  meas_sel,      // Reading kind.
	input  wire [2:0]  meas_vco,      // Oscillator.
	input  wire [6:0]  meas_point,    // Control point.
	input  wire        plug_start,    // Module start.
	input  wire        plug_slot,     // Module slot.
	input  wire        settings_save, // Run start.
	input  wire [1:0]  mode,          // 0 good, 1 faulty, 2 silent.
	output reg         meas_done,     // Answer strobe.
	output reg  [15:0] meas_value,    // Answer value.
	output reg         plug_done,     // Module finished.
	output reg         plug_fail,     // Module failed.
	output reg         order_err,     // Oscillator order broken.
	output reg  [8:0]  vco_cnt        // Oscillator requests this run.
);
	reg [1:0]  wait_q;
	reg [1:0]  pwait_q;
	reg        slow_q;
	reg        tog_q;
	reg        pf_q;
	reg [2:0]  last_vco_q;
	reg [6:0]  last_pt_q;
	reg [15:0] val_d;
	wire       bad = (mode == 2'h1);
	wire       vco_ok = (meas_point == last_pt_q + 7'h01 && meas_vco == last_vco_q) ||
		(meas_point == 7'h00 && meas_vco == last_vco_q + 3'h1);
	always @* begin
		case (meas_sel)
			`SCS_SEL_ADC_GND: val_d = bad ? 16'h0002 : 16'h0000;
			`SCS_SEL_ADC_DIV: val_d = bad ? (tog_q ? 16'h07e4 : 16'h07d0) : 16'h0800;
			`SCS_SEL_FCNT:    val_d = bad ? (tog_q ? 16'hbb8a : 16'hbb76) : 16'hbb80;
			`SCS_SEL_TDC_CYC: val_d = bad ? 16'h1388 : 16'h0dac;
			`SCS_SEL_TDC_PED: val_d = 16'h0064;
			default:          val_d = bad ? 16'h6978 : 16'hea60 - 16'h012c * {9'h000, meas_point};
		endcase
	end
	// Answers alternate between fast and slow; a silent mode never answers, to force timeouts.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			{wait_q, pwait_q, slow_q, tog_q, pf_q, meas_done, plug_done, plug_fail} <= 10'h000;
			{order_err, vco_cnt, last_vco_q, last_pt_q} <= 20'h00000;
			meas_value <= 16'h0000;
		end else begin
			meas_done <= 1'b0;
			plug_done <= 1'b0;
			// The value lines show junk outside an answer.
			meas_value <= ~meas_value;
			plug_fail <= ~plug_fail;
			if (meas_req && mode != 2'h2) begin
				wait_q <= slow_q ? 2'h3 : 2'h1;
				slow_q <= ~slow_q;
			end else if (wait_q != 2'h0) begin
				wait_q <= wait_q - 2'h1;
				if (wait_q == 2'h1) begin
					meas_done <= 1'b1;
					meas_value <= val_d;
					tog_q <= ~tog_q;
				end
			end
			if (plug_start && mode != 2'h2) begin
				pwait_q <= 2'h2;
				pf_q <= bad && !plug_slot;
			end else if (pwait_q != 2'h0) begin
				pwait_q <= pwait_q - 2'h1;
				if (pwait_q == 2'h1) begin
					plug_done <= 1'b1;
					plug_fail <= pf_q;
				end
			end
			if (settings_save) begin
				last_vco_q <= 3'h7;
				vco_cnt <= 9'h000;
			end else if (meas_req && meas_sel == `SCS_SEL_VCO) begin
				if (!vco_ok) order_err <= 1'b1;
				last_vco_q <= meas_vco;
				last_pt_q <= meas_point;
				vco_cnt <= vco_cnt + 9'h001;
			end
		end
	end
endmodule

// ### bench/scs_seq_sva.sv
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_seq_chk (
	input wire        clk,              // Clock.
	input wire        rst,              // Reset.
	input wire        psel,             // APB.
	input wire        penable,          // APB.
	input wire        pwrite,           // APB.
	input wire [7:0]  paddr,            // APB.
	input wire [31:0] pwdata,           // APB.
	input wire        pready,           // APB.
	input wire [31:0] prdata,           // APB.
	input wire        pslverr,          // APB.
	input wire        meas_req,         // Request.
	input wire [2:0]  meas_sel,         // Kind.
	input wire [2:0]  meas_vco,         // Oscillator.
	input wire [6:0]  meas_point,       // Point.
	input wire [31:0] meas_gate_us,     // Gate.
	input wire        meas_done,        // Answer.
	input wire [15:0] meas_value,       // Value.
	input wire        plug_start,       // Module start.
	input wire        plug_slot,        // Slot.
	input wire        plug_done,        // Module done.
	input wire        plug_fail,        // Module fail.
	input wire        settings_save,    // Snapshot.
	input wire        settings_restore  // Restore.
);
	reg run_q;
	reg plug_a_q;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
			plug_a_q <= 1'b0;
		end else begin
			run_q <= settings_save | (run_q & ~settings_restore);
			plug_a_q <= ~settings_save & (plug_a_q | (plug_start & ~plug_slot));
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_req_one_cycle: assert property (meas_req |=> !meas_req)
		else $error("request longer than one cycle");
	a_counter_gate: assert property (meas_req && meas_sel == `SCS_SEL_FCNT |->
		meas_gate_us == `SCS_FCNT_GATE_US) else $error("counter gate not 3 ms");
	a_vco_first_gate: assert property (meas_req && meas_sel == `SCS_SEL_VCO &&
		meas_point == 7'h00 |-> meas_gate_us == `SCS_VCO_GATE_US) else $error("first gate not 9 ms");
	a_sel_holds: assert property (meas_req |=> $stable(meas_sel) && $stable(meas_vco) &&
		$stable(meas_point)) else $error("selection moved while waiting");
	a_req_in_run: assert property (meas_req |-> run_q || settings_save)
		else $error("request outside a run");
	a_restore_in_run: assert property (settings_restore |-> run_q && !settings_save)
		else $error("restore without a saved snapshot");
	a_slot_order: assert property (plug_start && plug_slot |-> plug_a_q)
		else $error("slot B before slot A");
	a_quiet_end: assert property (settings_restore |=> (!meas_req && !plug_start)[*4])
		else $error("activity after restore");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h2c |=>
		pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
	c_end: cover property (settings_restore);
	c_last_point: cover property (meas_req && meas_vco == 3'h4 && meas_point == 7'h4b);
	c_slot_b: cover property (plug_start && plug_slot);
endmodule
bind scs_seq scs_seq_chk u_chk (.*);

// ### bench/self_calibration_sequencer_tb.sv
`timescale 1ns/1ps
`include "scs_consts.vh"
module self_calibration_sequencer_tb;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rdat, prdata, meas_gate_us;
	logic [1:0] mode = 2'h0;
	logic pready, pslverr, rerr, meas_req, meas_done, plug_start, plug_slot, plug_done, plug_fail;
	logic settings_save, settings_restore, order_err;
	logic [2:0] meas_sel, meas_vco;
	logic [6:0] meas_point;
	logic [15:0] meas_value;
	logic [8:0] vco_cnt;
	integer miscompares = 0, cmp_count = 0;
	always #4 clk = ~clk;
	// Identity values below are arbitrary.
	scs_seq #(.TMO_CYC(32'h32), .ID_MFR(32'h0000_5a31), .ID_MODEL(32'h0000_0007),
		.ID_SERIAL(32'h0000_0000), .ID_FW(32'h0000_0203)) DUT (.*);
	scs_meas_model u_model (.*);
	task tally_and_finish;
		$display("compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		integer n;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 100) begin
			n = n + 1;
			@(posedge clk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100) begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask
	// Starts a run with the partner in the given mode and polls until done.
	task run_cal(input logic [1:0] m, input logic [8:0] vco_exp);
		integer n;
		mode <= m;
		apb(1'b1, `SCS_REG_CTRL, 32'h1);
		rd(`SCS_REG_STATUS, 32'h1);
		n = 0;
		while (rdat[`SCS_STAT_DONE] !== 1'b1 && n < 20000) begin
			apb(1'b0, `SCS_REG_STATUS, 32'h0);
			n = n + 1;
		end
		if (n >= 20000) begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
		check({23'h0, vco_cnt}, {23'h0, vco_exp});
		check({31'h0, order_err}, 32'h0);
		$display("run in mode %0d done", m);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`SCS_REG_ID_MFR, 32'h0000_5a31);
		rd(`SCS_REG_ID_MODEL, 32'h0000_0007);
		rd(`SCS_REG_ID_SERIAL, 32'h0000_0000);
		rd(`SCS_REG_ID_FW, 32'h0000_0203);
		rd(8'h30, 32'h0);
		check({31'h0, rerr}, 32'h1);
		$display("identity test done");
		run_cal(2'h1, 9'h17c);
		rd(`SCS_REG_RESULT, 32'h0000_0117);
		rd(`SCS_REG_DETAIL, 32'h0104_0203);
		rd(`SCS_REG_ADC_SUMS, 32'h4e84_0014);
		run_cal(2'h2, 9'h005);
		rd(`SCS_REG_RESULT, 32'h0000_0317);
		rd(`SCS_REG_DETAIL, 32'h0401_0102);
		run_cal(2'h0, 9'h17c);
		rd(`SCS_REG_RESULT, 32'h0000_0000);
		rd(`SCS_REG_DETAIL, 32'h0000_0000);
		rd(`SCS_REG_ADC_SUMS, 32'h5000_0000);
		rd(`SCS_REG_TDC_OFFS, 32'h0001_86a0);
		rd(`SCS_REG_TDC_RES, 32'h0000_0000);
		rd(`SCS_REG_VCO_LAST, 32'h0200_927c);
		tally_and_finish;
	end
endmodule

// ### rtl/scs_consts.vh
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// Register byte offsets.
`define SCS_REG_CTRL       8'h00
`define SCS_REG_STATUS     8'h04
`define SCS_REG_RESULT     8'h08
`define SCS_REG_DETAIL     8'h0c
`define SCS_REG_ADC_SUMS   8'h10
`define SCS_REG_TDC_OFFS   8'h14
`define SCS_REG_TDC_RES    8'h18
`define SCS_REG_VCO_LAST   8'h1c
`define SCS_REG_ID_MFR     8'h20
`define SCS_REG_ID_MODEL   8'h24
`define SCS_REG_ID_SERIAL  8'h28
`define SCS_REG_ID_FW      8'h2c

// Field positions.
`define SCS_CTRL_START     0
`define SCS_STAT_BUSY      0
`define SCS_STAT_DONE      1
`define SCS_RES_ADC        0
`define SCS_RES_FCNT       1
`define SCS_RES_TDC        2
`define SCS_RES_VCO        4
`define SCS_RES_PLGA       8
`define SCS_RES_PLGB       9

// Detail codes.
`define SCS_CODE_1         8'h01
`define SCS_CODE_2         8'h02
`define SCS_CODE_4         8'h04

// Measurement selector encodings.
`define SCS_SEL_NONE       3'h0
`define SCS_SEL_ADC_GND    3'h1
`define SCS_SEL_ADC_DIV    3'h2
`define SCS_SEL_FCNT       3'h3
`define SCS_SEL_TDC_CYC    3'h4
`define SCS_SEL_TDC_PED    3'h5
`define SCS_SEL_VCO        3'h6

// Counts and limits.
`define SCS_N_ADC          10'd10
`define SCS_N_FCNT         10'd10
`define SCS_N_TDC_CYC      10'd1000
`define SCS_N_TDC_PED      10'd250
`define SCS_ADC_SPREAD     16'd10
`define SCS_ADC_GND_MAX    16'd1
`define SCS_ADC_DIV_HI     16'd2150
`define SCS_ADC_DIV_LO     16'd1945
`define SCS_FCNT_SPREAD    16'd10
`define SCS_FCNT_SUM_LO    32'd479920
`define SCS_FCNT_SUM_HI    32'd480080
`define SCS_PED_SPREAD     16'd64
`define SCS_CYC_SPREAD     16'd220
`define SCS_PED_SUM_LO     32'd12500
`define SCS_PED_SUM_HI     32'd100000
`define SCS_CYC_SUM_LO     32'd3000000
`define SCS_CYC_SUM_HI     32'd4000000
`define SCS_RES_DIVISOR    32'd62500000
`define SCS_VCO_COUNT      3'd5
`define SCS_VCO_POINTS     7'd76
`define SCS_VCO_ABORT      16'd20000
`define SCS_VCO_LOW        16'd25000
`define SCS_VCO_STRETCH    16'd30000
`define SCS_VCO_FAST_MUL   48'd1792
`define SCS_VCO_GATE_MUL   48'd10000

// Timing.
`define SCS_CLK_NS         8
`define SCS_FCNT_GATE_US   32'd3000
`define SCS_VCO_GATE_US    32'd9000
`define SCS_TMO_MS         10
`define SCS_TMO_CYC        ((`SCS_TMO_MS * 1000000) / `SCS_CLK_NS)

`endif

// ### rtl/scs_seq.v
// Overview of operation
// - ADC check takes ten grounded and ten divider conversions, keeping sum, min, max.
// - ADC detail code 1 when spread at either voltage exceeds ten codes.
// - ADC code 2 when ground exceeds one, or divider above 2150 or below 1945.
// - Any ADC failure sets result bit 0.
// - Counter check counts reference through 3 ms gate, ten times.
// - Counter code 2 when count spread exceeds ten.
// - Counter code 4 when average count lies outside 47992 to 48008.
// - Counter code 1 on gate-end timeout; any counter failure sets bit 1.
// - Interval check sums 1000 one-cycle and 250 offset readings, offset scaled four.
// - Store offset times 1000 and resolution: difference divided by 62500000.
// - Interval code 4 for offset average outside 50-400 or cycle outside 3000-4000.
// - Interval code 2 for offset spread over 64 or cycle spread over 220.
// - Interval code 1 on stop timeout; any interval failure sets bit 2.
// - Oscillator calibration runs five times in fixed order.
// - Each oscillator measured at 76 points unless aborted, highest frequency first.
// - Gate starts 9 ms and grows by 1.25 after a count below 30000.
// - Codes 1 low or slow, 2 non-monotonic, 4 abort under 20000; bit 4.
// - Module slots A and B calibrate; failures set bits 8 and 9.
// - Settings held before calibration are restored when the sequence ends.
// - Identification gives manufacturer, model, serial or zero, firmware level.
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_seq #(
	parameter [31:0] TMO_CYC   = `SCS_TMO_CYC, // Answer timeout in cycles.
	parameter [31:0] ID_MFR    = 32'h0000_00a5, // Arbitrary value.
	parameter [31:0] ID_MODEL  = 32'h0000_0001, // Arbitrary value.
	parameter [31:0] ID_SERIAL = 32'h0000_0000, // Zero when unknown.
	parameter [31:0] ID_FW     = 32'h0000_0100  // Arbitrary value.
) (
	input  wire        clk,             // System clock, 125 MHz.
	input  wire        rst,             // Asynchronous reset, active high.
	input  wire        psel,            // APB select.
	input  wire        penable,         // APB access phase.
	input  wire        pwrite,          // APB direction.
	input  wire [7:0]  paddr,           // APB byte address.
	input  wire [31:0] pwdata,          // APB write data.
	output wire        pready,          // APB ready.
	output reg  [31:0] prdata,          // APB read data.
	output reg         pslverr,         // APB error for unmapped address.
	output reg         meas_req,        // One-cycle measurement request.
	output wire [2:0]  meas_sel,        // Which measurement.
	output reg  [2:0]  meas_vco,        // Oscillator under calibration.
	output reg  [6:0]  meas_point,      // Stored control-voltage point.
	output wire [31:0] meas_gate_us,    // Counting gate in microseconds.
	input  wire        meas_done,       // One-cycle answer strobe.
	input  wire [15:0] meas_value,      // Reading or count.
	output reg         plug_start,      // One-cycle module calibration start.
	output reg         plug_slot,       // Zero for slot A, one for slot B.
	input  wire        plug_done,       // Module calibration finished.
	input  wire        plug_fail,       // Module calibration failed.
	output reg         settings_save,   // Pulse: snapshot user settings.
	output reg         settings_restore // Pulse: restore snapshot.
);
	localparam [3:0] ST_IDLE = 4'd0;
	localparam [3:0] ST_SAVE = 4'd1;
	localparam [3:0] ST_ADCG = 4'd2;
	localparam [3:0] ST_ADCD = 4'd3;
	localparam [3:0] ST_FCNT = 4'd4;
	localparam [3:0] ST_TDCC = 4'd5;
	localparam [3:0] ST_TDCP = 4'd6;
	localparam [3:0] ST_VCO  = 4'd7;
	localparam [3:0] ST_PLGA = 4'd8;
	localparam [3:0] ST_PLGB = 4'd9;
	localparam [3:0] ST_REST = 4'd10;

	reg  [3:0]  st_q;
	reg         wait_q;
	reg         eval_q;
	reg  [9:0]  n_q;
	reg  [31:0] tmo_q;
	reg         busy_q;
	reg         done_q;
	reg  [31:0] result_q;
	reg  [7:0]  det_adc_q;
	reg  [7:0]  det_fcnt_q;
	reg  [7:0]  det_tdc_q;
	reg  [7:0]  det_vco_q;
	reg  [15:0] adc_gnd_sum_q;
	reg  [15:0] adc_div_sum_q;
	reg  [31:0] cyc_sum_q;
	reg  [31:0] ped_x1000_q;
	reg  [31:0] res_q;
	reg  [31:0] gate_q;
	reg  [15:0] prev_q;
	reg  [2:0]  sel_q;
	reg  [9:0]  target;
	reg  [31:0] rd;
	reg         hit;
	wire [31:0] sum;
	wire [15:0] mn;
	wire [15:0] mx;
	wire [15:0] spread;
	wire        stat_st;
	wire        got;
	wire        tmo_hit;
	wire        start_wr;
	wire [31:0] ped_scaled;
	wire [47:0] fast_lhs;
	wire [47:0] fast_rhs;

	assign pready = 1'b1;
	assign start_wr = psel & penable & pwrite & (paddr == `SCS_REG_CTRL) & pwdata[`SCS_CTRL_START];
	assign got = wait_q & meas_done;
	assign tmo_hit = wait_q & ~meas_done & ~plug_done & (tmo_q == TMO_CYC - 32'd1);
	assign stat_st = (st_q == ST_ADCG) | (st_q == ST_ADCD) | (st_q == ST_FCNT) |
			 (st_q == ST_TDCC) | (st_q == ST_TDCP);
	assign spread = mx - mn;
	assign ped_scaled = {sum[29:0], 2'b00};
	assign meas_sel = sel_q;
	assign meas_gate_us = (st_q == ST_FCNT) ? `SCS_FCNT_GATE_US :
			      (st_q == ST_VCO) ? gate_q : 32'h0000_0000;
	// The slowest allowed fastest period is checked without a divider.
	assign fast_lhs = {16'h0000, gate_q} * `SCS_VCO_GATE_MUL;
	assign fast_rhs = {32'h0000_0000, meas_value} * `SCS_VCO_FAST_MUL;

	scs_stat #(
		.VW(16),
		.SW(32)
	) u_stat (
		.clk  (clk),
		.rst  (rst),
		.clr  (eval_q | tmo_hit | (st_q == ST_SAVE)),
		.smp  (stat_st & got),
		.val  (meas_value),
		.sum_q(sum),
		.min_q(mn),
		.max_q(mx)
	);

	always @* begin
		case (st_q)
			ST_ADCG: target = `SCS_N_ADC;
			ST_ADCD: target = `SCS_N_ADC;
			ST_FCNT: target = `SCS_N_FCNT;
			ST_TDCC: target = `SCS_N_TDC_CYC;
			ST_TDCP: target = `SCS_N_TDC_PED;
			default: target = 10'd1;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			wait_q <= 1'b0;
			eval_q <= 1'b0;
			n_q <= 10'd0;
			tmo_q <= 32'h0000_0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			result_q <= 32'h0000_0000;
			det_adc_q <= 8'h00;
			det_fcnt_q <= 8'h00;
			det_tdc_q <= 8'h00;
			det_vco_q <= 8'h00;
			adc_gnd_sum_q <= 16'h0000;
			adc_div_sum_q <= 16'h0000;
			cyc_sum_q <= 32'h0000_0000;
			ped_x1000_q <= 32'h0000_0000;
			res_q <= 32'h0000_0000;
			gate_q <= `SCS_VCO_GATE_US;
			prev_q <= 16'h0000;
			sel_q <= `SCS_SEL_NONE;
			meas_req <= 1'b0;
			meas_vco <= 3'd0;
			meas_point <= 7'd0;
			plug_start <= 1'b0;
			plug_slot <= 1'b0;
			settings_save <= 1'b0;
			settings_restore <= 1'b0;
		end else begin
			meas_req <= 1'b0;
			plug_start <= 1'b0;
			settings_save <= 1'b0;
			settings_restore <= 1'b0;
			eval_q <= 1'b0;
			tmo_q <= wait_q ? tmo_q + 32'd1 : 32'h0000_0000;
			if (stat_st & got) begin
				wait_q <= 1'b0;
				if (n_q + 10'd1 == target) begin
					n_q <= 10'd0;
					eval_q <= 1'b1;
				end else begin
					n_q <= n_q + 10'd1;
				end
			end
			case (st_q)
				ST_IDLE: begin
					if (start_wr) begin
						result_q <= 32'h0000_0000;
						det_adc_q <= 8'h00;
						det_fcnt_q <= 8'h00;
						det_tdc_q <= 8'h00;
						det_vco_q <= 8'h00;
						busy_q <= 1'b1;
						done_q <= 1'b0;
						settings_save <= 1'b1;
						st_q <= ST_SAVE;
					end
				end
				ST_SAVE: begin
					n_q <= 10'd0;
					// A timed-out interval check jumps straight into oscillator calibration,
					// so the oscillator walk must be rewound here and not on the way out.
					meas_vco <= 3'd0;
					meas_point <= 7'd0;
					gate_q <= `SCS_VCO_GATE_US;
					st_q <= ST_ADCG;
				end
				ST_ADCG, ST_ADCD, ST_FCNT, ST_TDCC, ST_TDCP: begin
					if (tmo_hit) begin
						wait_q <= 1'b0;
						n_q <= 10'd0;
						case (st_q)
							ST_ADCG, ST_ADCD: begin
								det_adc_q <= det_adc_q | `SCS_CODE_2;
								result_q[`SCS_RES_ADC] <= 1'b1;
								st_q <= ST_FCNT;
							end
							ST_FCNT: begin
								det_fcnt_q <= det_fcnt_q | `SCS_CODE_1;
								result_q[`SCS_RES_FCNT] <= 1'b1;
								st_q <= ST_TDCC;
							end
							default: begin
								det_tdc_q <= det_tdc_q | `SCS_CODE_1;
								result_q[`SCS_RES_TDC] <= 1'b1;
								st_q <= ST_VCO;
							end
						endcase
					end else if (eval_q) begin
						case (st_q)
							ST_ADCG: begin
								adc_gnd_sum_q <= sum[15:0];
								if (spread > `SCS_ADC_SPREAD) begin
									det_adc_q <= det_adc_q | `SCS_CODE_1;
									result_q[`SCS_RES_ADC] <= 1'b1;
								end
								if (mx > `SCS_ADC_GND_MAX) begin
									det_adc_q <= det_adc_q | `SCS_CODE_2 |
										((spread > `SCS_ADC_SPREAD) ? `SCS_CODE_1 : 8'h00);
									result_q[`SCS_RES_ADC] <= 1'b1;
								end
								st_q <= ST_ADCD;
							end
							ST_ADCD: begin
								adc_div_sum_q <= sum[15:0];
								if (spread > `SCS_ADC_SPREAD) begin
									det_adc_q <= det_adc_q | `SCS_CODE_1;
									result_q[`SCS_RES_ADC] <= 1'b1;
								end
								if ((mx > `SCS_ADC_DIV_HI) | (mn < `SCS_ADC_DIV_LO)) begin
									det_adc_q <= det_adc_q | `SCS_CODE_2 |
										((spread > `SCS_ADC_SPREAD) ? `SCS_CODE_1 : 8'h00);
									result_q[`SCS_RES_ADC] <= 1'b1;
								end
								st_q <= ST_FCNT;
							end
							ST_FCNT: begin
								det_fcnt_q <= det_fcnt_q |
									((spread > `SCS_FCNT_SPREAD) ? `SCS_CODE_2 : 8'h00) |
									(((sum < `SCS_FCNT_SUM_LO) | (sum > `SCS_FCNT_SUM_HI)) ?
									 `SCS_CODE_4 : 8'h00);
								if ((spread > `SCS_FCNT_SPREAD) | (sum < `SCS_FCNT_SUM_LO) |
								    (sum > `SCS_FCNT_SUM_HI)) begin
									result_q[`SCS_RES_FCNT] <= 1'b1;
								end
								st_q <= ST_TDCC;
							end
							ST_TDCC: begin
								cyc_sum_q <= sum;
								det_tdc_q <= det_tdc_q |
									((spread > `SCS_CYC_SPREAD) ? `SCS_CODE_2 : 8'h00) |
									(((sum < `SCS_CYC_SUM_LO) | (sum > `SCS_CYC_SUM_HI)) ?
									 `SCS_CODE_4 : 8'h00);
								if ((spread > `SCS_CYC_SPREAD) | (sum < `SCS_CYC_SUM_LO) |
								    (sum > `SCS_CYC_SUM_HI)) begin
									result_q[`SCS_RES_TDC] <= 1'b1;
								end
								st_q <= ST_TDCP;
							end
							default: begin
								ped_x1000_q <= ped_scaled;
								res_q <= (cyc_sum_q - ped_scaled) / `SCS_RES_DIVISOR;
								det_tdc_q <= det_tdc_q |
									((spread > `SCS_PED_SPREAD) ? `SCS_CODE_2 : 8'h00) |
									(((sum < `SCS_PED_SUM_LO) | (sum > `SCS_PED_SUM_HI)) ?
									 `SCS_CODE_4 : 8'h00);
								if ((spread > `SCS_PED_SPREAD) | (sum < `SCS_PED_SUM_LO) |
								    (sum > `SCS_PED_SUM_HI)) begin
									result_q[`SCS_RES_TDC] <= 1'b1;
								end
								st_q <= ST_VCO;
							end
						endcase
					end else if (!wait_q) begin
						meas_req <= 1'b1;
						wait_q <= 1'b1;
						case (st_q)
							ST_ADCG: sel_q <= `SCS_SEL_ADC_GND;
							ST_ADCD: sel_q <= `SCS_SEL_ADC_DIV;
							ST_FCNT: sel_q <= `SCS_SEL_FCNT;
							ST_TDCC: sel_q <= `SCS_SEL_TDC_CYC;
							default: sel_q <= `SCS_SEL_TDC_PED;
						endcase
					end
				end
				ST_VCO: begin
					if (got | tmo_hit) begin
						wait_q <= 1'b0;
						if (tmo_hit | (meas_value < `SCS_VCO_ABORT)) begin
							det_vco_q <= det_vco_q | `SCS_CODE_4;
							result_q[`SCS_RES_VCO] <= 1'b1;
							meas_point <= `SCS_VCO_POINTS; // Aborts this oscillator only.
						end else begin
							if ((meas_value < `SCS_VCO_LOW) |
							    ((meas_point == 7'd0) & (fast_lhs > fast_rhs))) begin
								det_vco_q <= det_vco_q | `SCS_CODE_1 |
									(((meas_point != 7'd0) & (meas_value > prev_q)) ?
									 `SCS_CODE_2 : 8'h00);
								result_q[`SCS_RES_VCO] <= 1'b1;
							end else if ((meas_point != 7'd0) & (meas_value > prev_q)) begin
								det_vco_q <= det_vco_q | `SCS_CODE_2;
								result_q[`SCS_RES_VCO] <= 1'b1;
							end
							if (meas_value < `SCS_VCO_STRETCH) begin
								gate_q <= gate_q + {2'b00, gate_q[31:2]};
							end
							prev_q <= meas_value;
							meas_point <= meas_point + 7'd1;
						end
					end else if (meas_point == `SCS_VCO_POINTS) begin
						meas_point <= 7'd0;
						gate_q <= `SCS_VCO_GATE_US;
						if (meas_vco == `SCS_VCO_COUNT - 3'd1) begin
							st_q <= ST_PLGA;
						end else begin
							meas_vco <= meas_vco + 3'd1;
						end
					end else if (!wait_q) begin
						sel_q <= `SCS_SEL_VCO;
						meas_req <= 1'b1;
						wait_q <= 1'b1;
					end
				end
				ST_PLGA, ST_PLGB: begin
					sel_q <= `SCS_SEL_NONE;
					if ((wait_q & plug_done) | tmo_hit) begin
						wait_q <= 1'b0;
						if (plug_fail | tmo_hit) begin
							result_q[plug_slot ? `SCS_RES_PLGB : `SCS_RES_PLGA] <= 1'b1;
						end
						st_q <= plug_slot ? ST_REST : ST_PLGB;
					end else if (!wait_q) begin
						plug_slot <= (st_q == ST_PLGB);
						plug_start <= 1'b1;
						wait_q <= 1'b1;
					end
				end
				ST_REST: begin
					settings_restore <= 1'b1;
					busy_q <= 1'b0;
					done_q <= 1'b1;
					plug_slot <= 1'b0;
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always @* begin
		hit = 1'b1;
		case (paddr)
			`SCS_REG_CTRL:      rd = 32'h0000_0000;
			`SCS_REG_STATUS:    rd = {30'h0000_0000, done_q, busy_q};
			`SCS_REG_RESULT:    rd = result_q;
			`SCS_REG_DETAIL:    rd = {det_vco_q, det_tdc_q, det_fcnt_q, det_adc_q};
			`SCS_REG_ADC_SUMS:  rd = {adc_div_sum_q, adc_gnd_sum_q};
			`SCS_REG_TDC_OFFS:  rd = ped_x1000_q;
			`SCS_REG_TDC_RES:   rd = res_q;
			`SCS_REG_VCO_LAST:  rd = {6'h00, meas_vco, meas_point, prev_q};
			`SCS_REG_ID_MFR:    rd = ID_MFR;
			`SCS_REG_ID_MODEL:  rd = ID_MODEL;
			`SCS_REG_ID_SERIAL: rd = ID_SERIAL;
			`SCS_REG_ID_FW:     rd = ID_FW;
			default: begin
				rd = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flop in the access phase.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & ~penable) begin
			prdata <= pwrite ? 32'h0000_0000 : rd;
			pslverr <= ~hit;
		end
	end
endmodule

// ### rtl/scs_stat.v
`timescale 1ns/1ps
module scs_stat #(
	parameter VW = 16,
	parameter SW = 32
) (
	input  wire          clk,   // System clock.
	input  wire          rst,   // Asynchronous reset, active high.
	input  wire          clr,   // Restart the group.
	input  wire          smp,   // Take one reading.
	input  wire [VW-1:0] val,   // Reading.
	output reg  [SW-1:0] sum_q, // Sum of readings.
	output reg  [VW-1:0] min_q, // Smallest reading.
	output reg  [VW-1:0] max_q  // Largest reading.
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sum_q <= {SW{1'b0}};
			min_q <= {VW{1'b1}};
			max_q <= {VW{1'b0}};
		end else if (clr) begin
			sum_q <= {SW{1'b0}};
			min_q <= {VW{1'b1}};
			max_q <= {VW{1'b0}};
		end else if (smp) begin
			sum_q <= sum_q + {{(SW-VW){1'b0}}, val};
			if (val < min_q) begin
				min_q <= val;
			end
			if (val > max_q) begin
				max_q <= val;
			end
		end
	end
endmodule
